/* File: include/spc_pkg.sv */
// Purpose: Types of the port parameter unit.
// Assumes: Nothing.
// Notes: Numbers live in spc_regs.svh.
package spc_pkg;
    // Sequencer states.
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CHECK = 2'b01,
        ST_NV_WAIT = 2'b10
    } fsm_type;
    // Storage operations.
    typedef enum logic [1:0] {
        OP_NONE = 2'b00,
        OP_WRITE = 2'b01,
        OP_READ = 2'b10,
        OP_CLEAR = 2'b11
    } op_type;
    // Request to the non-volatile store.
    typedef struct packed {
        logic req;
        op_type op;
        logic port;
        logic [2:0] sel;
        logic [7:0] addr;
        logic [7:0] baud;
        logic [7:0] par;
    } nv_req_type;
    // Answer of the non-volatile store.
    typedef struct packed {
        logic [2:0] fail;
        logic [2:0] present;
        logic [7:0] addr;
        logic [7:0] baud;
        logic [7:0] par;
    } nv_rsp_type;
    // Whole state of the unit.
    typedef struct packed {
        fsm_type fsm;
        logic [7:0] ctrl;
        logic [7:0] sel;
        logic [7:0] result;
        logic [7:0] v_addr;
        logic [7:0] v_baud;
        logic [7:0] v_par;
        logic [2:0] go;
        logic [3:0] port;
        nv_req_type nv;
        logic [1:0][2:0] dyn_ok;
        logic [1:0][7:0] dyn_addr;
        logic [1:0][7:0] dyn_baud;
        logic [1:0][7:0] dyn_par;
        logic [1:0][7:0] eff_addr;
        logic [1:0][7:0] eff_baud;
        logic [1:0][7:0] eff_par;
        logic booted;
        logic [7:0] rdata;
    } state_type;
endpackage : spc_pkg

/* File: include/spc_regs.svh */
// Purpose: Offsets, bit positions, limits and codes of the port parameter unit.
// Assumes: Included by its bare name after the package.
// Notes: Definitions only.
`ifndef SPC_REGS_SVH
`define SPC_REGS_SVH
// Register indices on the software port.
`define SPC_OFS_CTRL 3'h0
`define SPC_OFS_SEL 3'h1
`define SPC_OFS_RESULT 3'h2
`define SPC_OFS_ADDR 3'h3
`define SPC_OFS_BAUD 3'h4
`define SPC_OFS_PAR 3'h5
// Command byte fields.
`define SPC_GO_HI 7
`define SPC_GO_LO 5
`define SPC_PORT_HI 3
`define SPC_PORT_LO 0
`define SPC_PORT_A 4'h1
`define SPC_PORT_B 4'h2
// Select byte fields.
`define SPC_SEL_RSVD_MASK 8'hf8
`define SPC_SEL_ALL 3'h7
// Value limits.
`define SPC_ADDR_MIN 8'h01
`define SPC_ADDR_MAX 8'h1f
`define SPC_BAUD_MIN 8'h00
`define SPC_BAUD_MAX 8'h05
`define SPC_PAR_MIN 8'h00
`define SPC_PAR_MAX 8'h02
// Result codes.
`define SPC_ERR_NONE 6'h00
`define SPC_ERR_CMD 6'h01
`define SPC_ERR_PORT 6'h02
`define SPC_ERR_SEL 6'h03
`define SPC_ERR_ADDR 6'h04
`define SPC_ERR_BAUD 6'h05
`define SPC_ERR_PAR 6'h06
`define SPC_ERR_BASE_A 6'h0a
`define SPC_ERR_BASE_B 6'h14
`define SPC_ERR_NV_WR 6'h3d
`endif

/* File: logic/serial_port_param_cmd_unit.sv */
// Purpose: Command unit that writes, reads or clears the station address,
//   baud code and parity code of two serial ports.
// Assumes: One clock; storage and UART share it, so their signals need no
//   synchroniser.
// Notes: The store itself sits outside; this unit sequences it.
`include "spc_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module serial_port_param_cmd_unit (
    input wire logic i_core_clk, // Core clock, 25 MHz.
    input wire logic i_rst_n, // Asynchronous reset, active low.
    input wire logic [2:0] i_addr, // Register index.
    input wire logic [7:0] i_wdata, // Write data.
    input wire logic i_wr, // Write strobe.
    input wire logic i_rd, // Read strobe.
    output logic [7:0] o_rdata, // Read data, one cycle after i_rd.
    input wire logic [1:0][7:0] i_cfg_addr, // Configured address per port.
    input wire logic [1:0][7:0] i_cfg_baud, // Configured baud code per port.
    input wire logic [1:0][7:0] i_cfg_par, // Configured parity per port.
    input wire logic [1:0] i_port_busy, // Port is in a transfer.
    output logic [1:0][7:0] o_eff_addr, // Address in force per port.
    output logic [1:0][7:0] o_eff_baud, // Baud code in force per port.
    output logic [1:0][7:0] o_eff_par, // Parity code in force per port.
    output spc_pkg::nv_req_type o_nv, // Request to the store.
    input wire logic i_nv_ack, // Store finished, one-cycle pulse.
    input wire spc_pkg::nv_rsp_type i_nv_rsp // Store answer, valid on ack.
);

    // Registered state and its next value.
    spc_pkg::state_type q;
    spc_pkg::state_type d;
    // Temporaries of the combinational process.
    logic [5:0] chk_code; // Validation result.
    logic [5:0] rd_code; // Storage read result.
    logic [5:0] base; // Storage code base of the port.
    logic pidx; // Port index, zero for the first port.
    logic clr_hit; // Software writes the command byte now.

    // Range test shared by all three values.
    function automatic logic in_range(input logic [7:0] v,
                                      input logic [7:0] lo,
                                      input logic [7:0] hi);
        in_range = (v >= lo) && (v <= hi);
    endfunction : in_range

    // True when two or more go bits are set.
    function automatic logic many_go(input logic [2:0] g);
        many_go = (g[0] & g[1]) | (g[0] & g[2]) | (g[1] & g[2]);
    endfunction : many_go

    // Outputs come straight from the state register.
    assign o_rdata = q.rdata;
    assign o_eff_addr = q.eff_addr;
    assign o_eff_baud = q.eff_baud;
    assign o_eff_par = q.eff_par;
    assign o_nv = q.nv;

    // Next state: register port, sequencer and parameters in force.
    always_comb begin
        d = q;
        chk_code = `SPC_ERR_NONE;
        rd_code = `SPC_ERR_NONE;
        pidx = (q.port == `SPC_PORT_B);
        base = pidx ? `SPC_ERR_BASE_B : `SPC_ERR_BASE_A;
        clr_hit = i_wr && (i_addr == `SPC_OFS_CTRL);

        // Read data stand only in the cycle after the strobe.
        d.rdata = 8'h00;
        if (i_rd) begin
            unique case (i_addr)
                `SPC_OFS_CTRL: d.rdata = q.ctrl;
                `SPC_OFS_SEL: d.rdata = q.sel;
                `SPC_OFS_RESULT: d.rdata = q.result;
                `SPC_OFS_ADDR: d.rdata = q.v_addr;
                `SPC_OFS_BAUD: d.rdata = q.v_baud;
                `SPC_OFS_PAR: d.rdata = q.v_par;
                // Unused indices read as zero.
                default: d.rdata = 8'h00;
            endcase
        end

        // Software writes; the result byte is read-only.
        if (i_wr) begin
            unique case (i_addr)
                `SPC_OFS_CTRL: d.ctrl = i_wdata;
                `SPC_OFS_SEL: d.sel = i_wdata;
                `SPC_OFS_ADDR: d.v_addr = i_wdata;
                `SPC_OFS_BAUD: d.v_baud = i_wdata;
                `SPC_OFS_PAR: d.v_par = i_wdata;
                // Result and unused indices ignore writes.
                default: d.ctrl = d.ctrl;
            endcase
        end

        // Sequencer.
        unique case (q.fsm)
            spc_pkg::ST_IDLE: begin
                // A go bit seen while idle starts an operation.
                if (|q.ctrl[`SPC_GO_HI:`SPC_GO_LO]) begin
                    d.result = 8'h00;
                    d.go = q.ctrl[`SPC_GO_HI:`SPC_GO_LO];
                    d.port = q.ctrl[`SPC_PORT_HI:`SPC_PORT_LO];
                    d.fsm = spc_pkg::ST_CHECK;
                end
            end
            spc_pkg::ST_CHECK: begin
                // Checks run in priority order; the first fault wins.
                // single go bit
                if (many_go(q.go)) begin
                    chk_code = `SPC_ERR_CMD;
                end else if ((q.port != `SPC_PORT_A) && (q.port != `SPC_PORT_B)) begin
                    chk_code = `SPC_ERR_PORT;
                end else if (!q.go[1] && (((q.sel & `SPC_SEL_RSVD_MASK) != 8'h00)
                                          || (q.sel[2:0] == 3'h0))) begin
                    chk_code = `SPC_ERR_SEL;
                end else if (q.go[2]) begin
                    if (q.sel[0] && !in_range(q.v_addr, `SPC_ADDR_MIN, `SPC_ADDR_MAX)) begin
                        chk_code = `SPC_ERR_ADDR;
                    end else if (q.sel[1]
                                 && !in_range(q.v_baud, `SPC_BAUD_MIN, `SPC_BAUD_MAX)) begin
                        chk_code = `SPC_ERR_BAUD;
                    end else if (q.sel[2]
                                 && !in_range(q.v_par, `SPC_PAR_MIN, `SPC_PAR_MAX)) begin
                        chk_code = `SPC_ERR_PAR;
                    end
                end
                if (chk_code != `SPC_ERR_NONE) begin
                    d.result = {1'b1, 1'b0, chk_code};
                    if (!clr_hit) begin
                        d.ctrl[`SPC_GO_HI:`SPC_GO_LO] = 3'h0;
                    end
                    d.fsm = spc_pkg::ST_IDLE;
                end else begin
                    // Hand the operation to the store.
                    d.nv.req = 1'b1;
                    d.nv.port = pidx;
                    d.nv.addr = q.v_addr;
                    d.nv.baud = q.v_baud;
                    d.nv.par = q.v_par;
                    if (q.go[2]) begin
                        d.nv.op = spc_pkg::OP_WRITE;
                        d.nv.sel = q.sel[2:0];
                    end else if (q.go[1]) begin
                        d.nv.op = spc_pkg::OP_READ;
                        d.nv.sel = `SPC_SEL_ALL;
                    end else begin
                        d.nv.op = spc_pkg::OP_CLEAR;
                        d.nv.sel = q.sel[2:0];
                    end
                    d.fsm = spc_pkg::ST_NV_WAIT;
                end
            end
            spc_pkg::ST_NV_WAIT: begin
                // The request stands until the store acknowledges.
                if (i_nv_ack) begin
                    d.nv.req = 1'b0;
                    d.fsm = spc_pkg::ST_IDLE;
                    if (!clr_hit) begin
                        d.ctrl[`SPC_GO_HI:`SPC_GO_LO] = 3'h0;
                    end
                    unique case (q.nv.op)
                        spc_pkg::OP_READ: begin
                            // Lowest failing parameter is reported.
                            // codes of the addressed port
                            for (int k = 2; k >= 0; k--) begin
                                if (i_nv_rsp.fail[k]) begin
                                    rd_code = base + 6'(2 * k);
                                end else if (!i_nv_rsp.present[k]) begin
                                    rd_code = base + 6'(2 * k + 1);
                                end
                            end
                            if (rd_code != `SPC_ERR_NONE) begin
                                d.result = {1'b1, 1'b0, rd_code};
                            end else begin
                                d.result = {1'b1, 1'b1, `SPC_ERR_NONE};
                                d.v_addr = i_nv_rsp.addr;
                                d.v_baud = i_nv_rsp.baud;
                                d.v_par = i_nv_rsp.par;
                                // Refresh the mirror from the store.
                                d.dyn_ok[q.nv.port] = 3'h7;
                                d.dyn_addr[q.nv.port] = i_nv_rsp.addr;
                                d.dyn_baud[q.nv.port] = i_nv_rsp.baud;
                                d.dyn_par[q.nv.port] = i_nv_rsp.par;
                            end
                        end
                        default: begin
                            // Write and clear both change the store.
                            if (|i_nv_rsp.fail) begin
                                d.result = {1'b1, 1'b0, `SPC_ERR_NV_WR};
                            end else begin
                                d.result = {1'b1, 1'b1, `SPC_ERR_NONE};
                                if (q.nv.op == spc_pkg::OP_WRITE) begin
                                    d.dyn_ok[q.nv.port] = q.dyn_ok[q.nv.port] | q.nv.sel;
                                    if (q.nv.sel[0]) begin
                                        d.dyn_addr[q.nv.port] = q.nv.addr;
                                    end
                                    if (q.nv.sel[1]) begin
                                        d.dyn_baud[q.nv.port] = q.nv.baud;
                                    end
                                    if (q.nv.sel[2]) begin
                                        d.dyn_par[q.nv.port] = q.nv.par;
                                    end
                                end else begin
                                    d.dyn_ok[q.nv.port] = q.dyn_ok[q.nv.port] & ~q.nv.sel;
                                end
                            end
                        end
                    endcase
                end
            end
            // Illegal code recovers to idle.
            default: begin
                d.fsm = spc_pkg::ST_IDLE;
                d.nv.req = 1'b0;
            end
        endcase

        // Values in force; a stored value overrides the configured one.
        d.booted = 1'b1;
        for (int k = 0; k < 2; k++) begin
            d.eff_addr[k] = q.dyn_ok[k][0] ? q.dyn_addr[k] : i_cfg_addr[k];
            // A busy port keeps its framing until idle or restart.
            // baud and parity when idle
            if (!q.booted || !i_port_busy[k]) begin
                d.eff_baud[k] = q.dyn_ok[k][1] ? q.dyn_baud[k] : i_cfg_baud[k];
                d.eff_par[k] = q.dyn_ok[k][2] ? q.dyn_par[k] : i_cfg_par[k];
            end
        end
    end

    // State register; reset loads all zero, booted low forces a load.
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

endmodule : serial_port_param_cmd_unit

`default_nettype wire

/* File: test/serial_port_param_cmd_unit_tb_top.sv */
// Purpose: Self-checking bench of the port parameter unit.
// Assumes: The bench answers the store itself, with a delay that varies.
// Notes: Ordinary cases are rows; reset, busy and readback cases follow.
`include "spc_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module serial_port_param_cmd_unit_tb_top;
    // One case: command, select, value bytes, store answer, expected result.
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] sel;
        logic [23:0] vals;
        logic [2:0] fail;
        logic [2:0] pres;
        logic [7:0] res;
    } row_type;
    logic core_clk = 1'b0; // Core clock.
    logic rst_n = 1'b0; // Reset, active low.
    logic wr = 1'b0, rd = 1'b0, ack = 1'b0; // Strobes and store answer pulse.
    logic [2:0] addr = 3'h0; // Register index.
    logic [7:0] wdata = 8'h00, rdata, v; // Bus data and a scratch byte.
    logic [1:0] busy = 2'h0; // Port transfer flags.
    logic [1:0][7:0] cfg_a = {8'h0b, 8'h0a}, cfg_b = {8'h02, 8'h01}, cfg_p = {8'h01, 8'h00};
    logic [1:0][7:0] ea, eb, ep; // Values in force.
    spc_pkg::nv_req_type nv; // Store request.
    spc_pkg::nv_rsp_type rsp = '0; // Store answer.
    int bad_count = 0, check_count = 0, cyc = 0, wait_cnt = 0, nv_dly = 0;
    row_type rows [$] = '{
        '{8'h81, 8'h07, 24'h050302, 3'h0, 3'h7, 8'hc0}, '{8'h82, 8'h07, 24'h1f0500, 3'h0, 3'h7, 8'hc0},
        '{8'h81, 8'h01, 24'h010000, 3'h0, 3'h7, 8'hc0}, '{8'hc1, 8'h07, 24'h050302, 3'h0, 3'h7, 8'h81},
        '{8'h61, 8'h07, 24'h050302, 3'h0, 3'h7, 8'h81}, '{8'he1, 8'h07, 24'h050302, 3'h0, 3'h7, 8'h81},
        '{8'h80, 8'h07, 24'h050302, 3'h0, 3'h7, 8'h82}, '{8'h83, 8'h07, 24'h050302, 3'h0, 3'h7, 8'h82},
        '{8'h8f, 8'h07, 24'h050302, 3'h0, 3'h7, 8'h82}, '{8'h81, 8'h00, 24'h050302, 3'h0, 3'h7, 8'h83},
        '{8'h81, 8'h09, 24'h050302, 3'h0, 3'h7, 8'h83}, '{8'h81, 8'h80, 24'h050302, 3'h0, 3'h7, 8'h83},
        '{8'h81, 8'h01, 24'h000302, 3'h0, 3'h7, 8'h84}, '{8'h81, 8'h01, 24'h200302, 3'h0, 3'h7, 8'h84},
        '{8'h81, 8'h02, 24'h050602, 3'h0, 3'h7, 8'h85}, '{8'h81, 8'h04, 24'h050303, 3'h0, 3'h7, 8'h86},
        '{8'h81, 8'h07, 24'h050302, 3'h2, 3'h7, 8'hbd}, '{8'h41, 8'h00, 24'h050302, 3'h0, 3'h7, 8'hc0},
        '{8'h41, 8'h00, 24'h050302, 3'h1, 3'h7, 8'h8a}, '{8'h41, 8'h00, 24'h050302, 3'h2, 3'h7, 8'h8c},
        '{8'h41, 8'h00, 24'h050302, 3'h4, 3'h7, 8'h8e}, '{8'h41, 8'h00, 24'h050302, 3'h0, 3'h6, 8'h8b},
        '{8'h41, 8'h00, 24'h050302, 3'h0, 3'h5, 8'h8d}, '{8'h41, 8'h00, 24'h050302, 3'h0, 3'h3, 8'h8f},
        '{8'h42, 8'h00, 24'h050302, 3'h1, 3'h7, 8'h94}, '{8'h42, 8'h00, 24'h050302, 3'h2, 3'h7, 8'h96},
        '{8'h42, 8'h00, 24'h050302, 3'h4, 3'h7, 8'h98}, '{8'h42, 8'h00, 24'h050302, 3'h0, 3'h6, 8'h95},
        '{8'h42, 8'h00, 24'h050302, 3'h0, 3'h5, 8'h97}, '{8'h42, 8'h00, 24'h050302, 3'h0, 3'h3, 8'h99},
        '{8'h21, 8'h02, 24'h000000, 3'h0, 3'h7, 8'hc0}, '{8'h22, 8'h07, 24'h000000, 3'h4, 3'h7, 8'hbd},
        '{8'h21, 8'h00, 24'h000000, 3'h0, 3'h7, 8'h83}};

    serial_port_param_cmd_unit u_dut (
        .i_core_clk(core_clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_cfg_addr(cfg_a), .i_cfg_baud(cfg_b),
        .i_cfg_par(cfg_p), .i_port_busy(busy), .o_eff_addr(ea), .o_eff_baud(eb),
        .o_eff_par(ep), .o_nv(nv), .i_nv_ack(ack), .i_nv_rsp(rsp));

    always #20 core_clk = ~core_clk;

    // Store stand-in: one-cycle answer after nv_dly waiting cycles; also the hang limit.
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        ack <= 1'b0;
        if (nv.req === 1'b1 && !ack) begin
            if (wait_cnt >= nv_dly) begin
                ack <= 1'b1;
                wait_cnt <= 0;
            end else begin
                wait_cnt <= wait_cnt + 1;
            end
        end
        if (cyc == 6000) begin
            bad_count++;
            stop_test();
        end
    end

    // Counts a comparison; four-state inequality so an unknown never matches.
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // One-cycle write strobe beside index and data.
    task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge core_clk);
        wr <= 1'b0;
    endtask : reg_wr

    // One-cycle read strobe; the answer is looked at in the cycle after it.
    task automatic reg_rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge core_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge core_clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask : reg_rd

    // Loads the operands, starts the command and polls the result under a bound.
    task automatic run_op(input row_type r);
        int n;
        rsp <= {r.fail, r.pres, 24'h070401};
        // reserved bits zero
        // Legal rows keep command bit 4 and select bits 7 to 3 at zero; the
        // rows that set them on purpose only probe the select refusal.
        reg_wr(`SPC_OFS_SEL, r.sel);
        reg_wr(`SPC_OFS_ADDR, r.vals[23:16]);
        reg_wr(`SPC_OFS_BAUD, r.vals[15:8]);
        reg_wr(`SPC_OFS_PAR, r.vals[7:0]);
        reg_wr(`SPC_OFS_CTRL, r.ctrl);
        reg_rd(`SPC_OFS_RESULT, v);
        check(v, 8'h00);
        // start when done or after 40 polls
        // The next operation is started once done reads one here, or after 40 polls.
        for (n = 0; n < 40 && v[7] !== 1'b1; n++) begin
            reg_rd(`SPC_OFS_RESULT, v);
        end
        check(v, r.res);
        reg_rd(`SPC_OFS_CTRL, v);
        check(v, r.ctrl & 8'h1f);
    endtask : run_op

    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test;
        $display("TB: checks %0d, mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : stop_test

    // Main sequence: reset, table of cases, then hand-written cases.
    initial begin
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge core_clk);
        check(ea[0], 8'h0a);
        check(eb[1], 8'h02);
        $display("reset test done");
        foreach (rows[i]) begin
            nv_dly = i % 3;
            run_op(rows[i]);
            $display("row %0d done", i);
        end
        // A full clear falls back to configuration, then a write lands while busy.
        run_op('{8'h21, 8'h07, 24'h000000, 3'h0, 3'h7, 8'hc0});
        check(eb[0], 8'h01);
        busy <= 2'h1;
        run_op('{8'h81, 8'h07, 24'h090201, 3'h0, 3'h7, 8'hc0});
        check(ea[0], 8'h09);
        check(eb[0], 8'h01);
        busy <= 2'h0;
        repeat (3) @(posedge core_clk);
        check(eb[0], 8'h02);
        check(ep[0], 8'h01);
        $display("busy test done");
        // Read returns stored values, which then override configuration.
        run_op('{8'h41, 8'h00, 24'h000000, 3'h0, 3'h7, 8'hc0});
        reg_rd(`SPC_OFS_ADDR, v);
        check(v, 8'h07);
        reg_rd(`SPC_OFS_BAUD, v);
        check(v, 8'h04);
        reg_rd(`SPC_OFS_PAR, v);
        check(v, 8'h01);
        check(ea[0], 8'h07);
        // The result byte ignores writes; an unmapped index reads zero.
        reg_wr(`SPC_OFS_RESULT, 8'hff);
        reg_rd(`SPC_OFS_RESULT, v);
        check(v, 8'hc0);
        reg_rd(3'h6, v);
        check(v, 8'h00);
        $display("readback test done");
        // A second reset empties the mirror, so configuration is in force again.
        rst_n <= 1'b0;
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge core_clk);
        check(ea[0], 8'h0a);
        check(ea[1], 8'h0b);
        $display("second reset test done");
        stop_test();
    end
endmodule : serial_port_param_cmd_unit_tb_top
`default_nettype wire

/* File: test/spc_checker.sv */
// Purpose: Concurrent checks on the store request of the port parameter unit.
// Assumes: One clock domain; reset is asynchronous and active low.
// Notes: Sees only top-level ports; bound at the foot of this file.
`timescale 1ns/1ps
`default_nettype none

module spc_checker (
    input wire logic i_core_clk, // Core clock.
    input wire logic i_rst_n, // Reset, active low.
    input wire logic i_nv_ack, // Store finished pulse.
    input wire spc_pkg::nv_req_type o_nv // Request to the store.
);
    // All checks share one clock and one reset.
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_n);

    a_req_held_steady: assert property (
        o_nv.req && !i_nv_ack |=> o_nv.req && $stable(o_nv))
        else $error("store request changed before its answer");
    a_ack_ends_req: assert property (o_nv.req && i_nv_ack |=> !o_nv.req)
        else $error("store request still raised after its answer");
    a_op_is_known: assert property (o_nv.req |-> o_nv.op != spc_pkg::OP_NONE)
        else $error("store request carries no operation");
    a_read_sel_all: assert property (
        o_nv.req && o_nv.op == spc_pkg::OP_READ |-> o_nv.sel == 3'h7)
        else $error("read request does not fetch all three values");
    a_sel_not_empty: assert property (
        o_nv.req && o_nv.op != spc_pkg::OP_READ |-> o_nv.sel != 3'h0)
        else $error("write or clear request with empty selection");
    a_addr_in_range: assert property (
        o_nv.req && o_nv.op == spc_pkg::OP_WRITE && o_nv.sel[0]
        |-> o_nv.addr inside {[8'h01:8'h1f]})
        else $error("address outside its range reached the store");
    a_baud_in_range: assert property (
        o_nv.req && o_nv.op == spc_pkg::OP_WRITE && o_nv.sel[1] |-> o_nv.baud <= 8'h05)
        else $error("baud code outside its range reached the store");
    a_par_in_range: assert property (
        o_nv.req && o_nv.op == spc_pkg::OP_WRITE && o_nv.sel[2] |-> o_nv.par <= 8'h02)
        else $error("parity code outside its range reached the store");

    // Main traffic kinds seen at the store.
    c_write_req: cover property (o_nv.req && o_nv.op == spc_pkg::OP_WRITE);
    c_read_req: cover property (o_nv.req && o_nv.op == spc_pkg::OP_READ);
    c_clear_req: cover property (o_nv.req && o_nv.op == spc_pkg::OP_CLEAR);
endmodule : spc_checker

bind serial_port_param_cmd_unit spc_checker u_chk (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_nv_ack(i_nv_ack),
    .o_nv(o_nv)
);
`default_nettype wire
